// ==== logic/crl_count_elem.sv ====
`timescale 1ns/1ns
module crl_count_elem #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Programming from the bus side
    input wire logic ctrl_wr,
    input wire logic cr_wr,
    input wire logic [CNT_W-1:0] cr_value,
    // Counter pins
    input wire logic cnt_clk,
    input wire logic cnt_gate,
    // Counting state
    output logic [CNT_W-1:0] ce_value,
    output logic out_level,
    output logic null_count
);

    logic cnt_clk_q;
    logic [CNT_W-1:0] cr_r;
    logic [CNT_W-1:0] ce_r;
    logic load_pend_r;
    logic armed_r;
    logic out_r;
    logic null_r;
    logic clk_rise;
    logic load_now;

    // Count clock edge; only a plain down count is modelled here.
    assign clk_rise = cnt_clk & ~cnt_clk_q;
    assign load_now = clk_rise & load_pend_r;

    // Edge history of the count clock.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_clk_q <= 1'b0;
        end else begin
            cnt_clk_q <= cnt_clk;
        end
    end

    // Count register holds the last complete value written.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cr_r <= '0;
        end else if (cr_wr) begin
            cr_r <= cr_value;
        end
    end

    // A fresh value waits for the next count clock edge.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            load_pend_r <= 1'b0;
        end else if (cr_wr) begin
            load_pend_r <= 1'b1;
        end else if (clk_rise) begin
            load_pend_r <= 1'b0;
        end
    end

    // Counting element.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ce_r <= '0;
        end else if (load_now) begin
            ce_r <= cr_r;
        end else if (clk_rise && armed_r && cnt_gate) begin
            ce_r <= ce_r - 1'b1;
        end
    end

    // Running flag and terminal count output.
    always_ff @(posedge ref_clk) begin
        if (!rst_n || ctrl_wr) begin
            armed_r <= 1'b0;
            out_r <= 1'b0;
        end else if (load_now) begin
            armed_r <= 1'b1;
            out_r <= 1'b0;
        end else if (clk_rise && armed_r && cnt_gate && ce_r == CNT_W'(1)) begin
            out_r <= 1'b1;
        end
    end

    // Null count: a write in the same cycle as a load keeps it set.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            null_r <= crl_pkg::NULL_RST;
        end else if (ctrl_wr || cr_wr) begin
            null_r <= 1'b1; // [RULE13]
        end else if (load_now) begin
            null_r <= 1'b0; // [RULE13]
        end
    end

    assign ce_value = ce_r;
    assign out_level = out_r;
    assign null_count = null_r;

endmodule

// ==== logic/crl_out_latch.sv ====
`timescale 1ns/1ns
module crl_out_latch #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Requests from the bus side
    input wire logic ctrl_wr,
    input wire logic cnt_latch_req,
    input wire logic sts_latch_req,
    input wire logic rd_done,
    input wire logic [1:0] access_size,
    // Live values
    input wire logic [CNT_W-1:0] ce_value,
    input wire logic [7:0] status_now,
    // Byte the next read returns
    output logic [7:0] rd_byte
);

    logic [CNT_W-1:0] output_latch_r;
    logic cnt_held_r;
    logic [7:0] sts_r;
    logic sts_held_r;
    crl_pkg::crl_byte_t rd_ptr_r;
    logic [CNT_W-1:0] value;
    logic last_byte;

    // Status goes first, then the held count, otherwise the live count.
    always_comb begin
        value = cnt_held_r ? output_latch_r : ce_value;
        if (sts_held_r) begin
            rd_byte = sts_r; // [RULE17]
        end else if (access_size == crl_pkg::ACC_MSB) begin
            rd_byte = value[15:8];
        end else if (access_size == crl_pkg::ACC_WORD && rd_ptr_r == crl_pkg::CRL_BYTE_HI) begin
            rd_byte = value[15:8]; // [RULE18]
        end else begin
            rd_byte = value[7:0]; // [RULE18]
        end
    end

    assign last_byte = (access_size != crl_pkg::ACC_WORD) || (rd_ptr_r == crl_pkg::CRL_BYTE_HI);

    // Read byte pointer; a status read does not advance it.
    always_ff @(posedge ref_clk) begin
        if (!rst_n || ctrl_wr) begin
            rd_ptr_r <= crl_pkg::CRL_BYTE_LO;
        end else if (rd_done && !sts_held_r && access_size == crl_pkg::ACC_WORD) begin
            case (rd_ptr_r)
                crl_pkg::CRL_BYTE_LO: rd_ptr_r <= crl_pkg::CRL_BYTE_HI; // [RULE18]
                crl_pkg::CRL_BYTE_HI: rd_ptr_r <= crl_pkg::CRL_BYTE_LO;
                default: rd_ptr_r <= crl_pkg::CRL_BYTE_LO;
            endcase
        end
    end

    // Count latch: first request wins, released after its last byte.
    always_ff @(posedge ref_clk) begin
        if (!rst_n || ctrl_wr) begin
            cnt_held_r <= 1'b0; // [RULE3]
        end else if (rd_done && !sts_held_r && cnt_held_r && last_byte) begin
            cnt_held_r <= 1'b0; // [RULE9]
        end else if (cnt_latch_req && !cnt_held_r) begin
            cnt_held_r <= 1'b1; // [RULE2]
        end
    end

    // Captured count, untouched while a value is still unread.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            output_latch_r <= '0;
        end else if (cnt_latch_req && !cnt_held_r) begin
            output_latch_r <= ce_value; // [RULE4] [RULE10]
        end
    end

    // Status latch: first request wins, released by one read.
    always_ff @(posedge ref_clk) begin
        if (!rst_n || ctrl_wr) begin
            sts_held_r <= 1'b0;
            sts_r <= '0;
        end else if (rd_done && sts_held_r) begin
            sts_held_r <= 1'b0;
        end else if (sts_latch_req && !sts_held_r) begin
            sts_held_r <= 1'b1; // [RULE15]
            sts_r <= status_now;
        end
    end

endmodule

// ==== logic/crl_pkg.sv ====
package crl_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int NUM_CH = 3;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------------
    // Port addresses on the parallel bus
    // ------------------------------------------------------------------
    localparam logic [1:0] ADDR_CTRL_WORD = 2'h3;

    // ------------------------------------------------------------------
    // Control word fields
    // ------------------------------------------------------------------
    localparam int CW_SC_LO = 6;
    localparam int CW_RL_LO = 4;
    localparam int CW_SET_W = 6;
    localparam logic [1:0] SC_READ_BACK = 2'h3;
    localparam logic [1:0] ACC_LATCH = 2'h0;
    localparam logic [1:0] ACC_LSB = 2'h1;
    localparam logic [1:0] ACC_MSB = 2'h2;
    localparam logic [1:0] ACC_WORD = 2'h3;

    // ------------------------------------------------------------------
    // Read-back command fields
    // ------------------------------------------------------------------
    localparam int RB_COUNT_N_BIT = 5;
    localparam int RB_STATUS_N_BIT = 4;
    localparam int RB_SEL_LO = 1;

    // ------------------------------------------------------------------
    // Status byte layout and reset values
    // ------------------------------------------------------------------
    localparam int ST_OUT_BIT = 7;
    localparam int ST_NULL_BIT = 6;
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic NULL_RST = 1'b0;
    localparam logic [7:0] IDLE_READ = 8'h00;

    // ------------------------------------------------------------------
    // Byte pointer of a two-byte access
    // ------------------------------------------------------------------
    typedef enum logic {CRL_BYTE_LO, CRL_BYTE_HI} crl_byte_t;

endpackage

// ==== logic/crl_top.sv ====
// Notes on behaviour
// [RULE1] Host halts gate or clock before a direct unlatched read.
// [RULE2] Latch command copies the live count without disturbing counting.
// [RULE3] Latched count stays until read or a new control word.
// [RULE4] Further latch commands are ignored while a value is unread.
// [RULE5] Latch command: counter select in top bits, access field zero.
// [RULE6] Reading and writing one counter keep separate byte pointers.
// [RULE7] Read-back select bits 3, 2, 1 pick counters 2, 1, 0.
// [RULE8] Read-back has bits 7,6 set; bit 5 low count, bit 4 low status.
// [RULE9] Reading a counter releases only that counter's latches.
// [RULE10] Repeated read-back count latches before a read are ignored.
// [RULE11] Status low six bits hold the last control word settings.
// [RULE12] Status bit 7 shows the counter output pin level.
// [RULE13] Null count sets on writes, clears when count is loaded.
// [RULE14] Null count per counter; two-byte count sets it on byte two.
// [RULE15] Repeated status latches before a read are ignored.
// [RULE16] Count and status together act as two separate latches.
// [RULE17] With both latched, first read gives status, then count.
// [RULE18] Two-byte latched count reads low then high, then releases.
`timescale 1ns/1ns
module crl_top #(
    parameter int NUM_CH = crl_pkg::NUM_CH,
    parameter int CNT_W = crl_pkg::CNT_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Parallel host port
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [1:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // Counter pins
    input wire logic [NUM_CH-1:0] cnt_clk,
    input wire logic [NUM_CH-1:0] cnt_gate,
    output logic [NUM_CH-1:0] cnt_out
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------

    // True when a two-bit select names channel ch.
    function automatic logic sel_match(input logic [1:0] sel, input int ch);
        sel_match = (sel == 2'(ch));
    endfunction

    // True when a read-back command picks channel ch.
    function automatic logic rb_pick(input logic [7:0] cw, input int ch);
        rb_pick = cw[crl_pkg::RB_SEL_LO + ch]; // [RULE7]
    endfunction

    // ------------------------------------------------------------------
    // Bus strobe sampling
    // ------------------------------------------------------------------
    logic rd_n_q;
    logic wr_n_q;
    logic cs_n_q;
    logic [1:0] addr_q;
    logic [7:0] data_q;
    logic rd_start;
    logic rd_end;
    logic wr_end;
    logic rd_active_r;
    logic [1:0] rd_addr_r;
    logic [7:0] data_out_r;

    // The write is taken at the rising edge of the write strobe, with
    // address and data as they stood in the last cycle it was low.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            cs_n_q <= 1'b1;
            addr_q <= '0;
            data_q <= '0;
        end else begin
            rd_n_q <= rd_n;
            wr_n_q <= wr_n;
            cs_n_q <= cs_n;
            addr_q <= addr;
            data_q <= data_in;
        end
    end

    assign rd_start = rd_n_q & ~rd_n & ~cs_n & ~rd_active_r;
    assign rd_end = rd_active_r & rd_n;
    assign wr_end = ~wr_n_q & wr_n & ~cs_n_q;

    // ------------------------------------------------------------------
    // Control word decode
    // ------------------------------------------------------------------
    logic cw_wr;
    logic [1:0] cw_sel;
    logic [1:0] cw_acc;
    logic is_rb;

    assign cw_wr = wr_end & (addr_q == crl_pkg::ADDR_CTRL_WORD);
    assign cw_sel = data_q[crl_pkg::CW_SC_LO +: 2];
    assign cw_acc = data_q[crl_pkg::CW_RL_LO +: 2];
    assign is_rb = (cw_sel == crl_pkg::SC_READ_BACK); // [RULE8]

    // ------------------------------------------------------------------
    // Per-channel write path, latches and counting
    // ------------------------------------------------------------------
    logic [7:0] rd_byte [NUM_CH];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            logic ctrl_wr;
            logic data_wr;
            logic cnt_latch_req;
            logic sts_latch_req;
            logic rd_done;
            logic cr_wr;
            logic [CNT_W-1:0] cr_value;
            logic [CNT_W-1:0] ce_value;
            logic out_level;
            logic null_count;
            logic [7:0] status_now;
            logic [crl_pkg::CW_SET_W-1:0] ctrl_r;
            logic [7:0] lsb_hold_r;
            crl_pkg::crl_byte_t wr_ptr_r;

            // A control word with a zero access field is a latch command
            // and leaves the programmed settings alone.
            assign ctrl_wr = cw_wr & !is_rb & sel_match(cw_sel, gi) &
                             (cw_acc != crl_pkg::ACC_LATCH);
            assign data_wr = wr_end & sel_match(addr_q, gi);

            // Combined count and status requests are simply two requests.
            assign cnt_latch_req = cw_wr & ((!is_rb & sel_match(cw_sel, gi) &
                                   (cw_acc == crl_pkg::ACC_LATCH)) | // [RULE5]
                                   (is_rb & !data_q[crl_pkg::RB_COUNT_N_BIT] &
                                   rb_pick(data_q, gi))); // [RULE8] [RULE16]
            assign sts_latch_req = cw_wr & is_rb & !data_q[crl_pkg::RB_STATUS_N_BIT] &
                                   rb_pick(data_q, gi); // [RULE8] [RULE16]
            assign rd_done = rd_end & sel_match(rd_addr_r, gi); // [RULE9]

            // Status byte from live output level, null flag and settings.
            always_comb begin
                status_now = {out_level, null_count, ctrl_r}; // [RULE11] [RULE12]
            end

            // Last programmed settings of this channel.
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    ctrl_r <= crl_pkg::CTRL_RST;
                end else if (ctrl_wr) begin
                    ctrl_r <= data_q[crl_pkg::CW_SET_W-1:0]; // [RULE11]
                end
            end

            // Count register value; only a complete value reaches the
            // counting element, so the null flag waits for byte two.
            always_comb begin
                cr_wr = 1'b0;
                cr_value = '0;
                if (data_wr) begin
                    case (ctrl_r[crl_pkg::CW_RL_LO +: 2])
                        crl_pkg::ACC_LSB: begin
                            cr_wr = 1'b1;
                            cr_value = {8'h00, data_q};
                        end
                        crl_pkg::ACC_MSB: begin
                            cr_wr = 1'b1;
                            cr_value = {data_q, 8'h00};
                        end
                        crl_pkg::ACC_WORD: begin
                            cr_wr = (wr_ptr_r == crl_pkg::CRL_BYTE_HI); // [RULE14]
                            cr_value = {data_q, lsb_hold_r};
                        end
                        default: begin
                            cr_wr = 1'b0;
                        end
                    endcase
                end
            end

            // Write byte pointer, separate from the read pointer so that
            // reads and writes of one counter may interleave.
            always_ff @(posedge ref_clk) begin
                if (!rst_n || ctrl_wr) begin
                    wr_ptr_r <= crl_pkg::CRL_BYTE_LO;
                    lsb_hold_r <= '0;
                end else if (data_wr && ctrl_r[crl_pkg::CW_RL_LO +: 2] == crl_pkg::ACC_WORD) begin
                    case (wr_ptr_r)
                        crl_pkg::CRL_BYTE_LO: begin
                            wr_ptr_r <= crl_pkg::CRL_BYTE_HI; // [RULE6]
                            lsb_hold_r <= data_q;
                        end
                        crl_pkg::CRL_BYTE_HI: begin
                            wr_ptr_r <= crl_pkg::CRL_BYTE_LO; // [RULE6]
                        end
                        default: begin
                            wr_ptr_r <= crl_pkg::CRL_BYTE_LO;
                        end
                    endcase
                end
            end

            crl_count_elem #(
                .CNT_W(CNT_W)
            ) u_elem (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .ctrl_wr(ctrl_wr),
                .cr_wr(cr_wr),
                .cr_value(cr_value),
                .cnt_clk(cnt_clk[gi]),
                .cnt_gate(cnt_gate[gi]),
                .ce_value(ce_value),
                .out_level(out_level),
                .null_count(null_count)
            );

            crl_out_latch #(
                .CNT_W(CNT_W)
            ) u_latch (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .ctrl_wr(ctrl_wr),
                .cnt_latch_req(cnt_latch_req),
                .sts_latch_req(sts_latch_req),
                .rd_done(rd_done),
                .access_size(ctrl_r[crl_pkg::CW_RL_LO +: 2]),
                .ce_value(ce_value),
                .status_now(status_now),
                .rd_byte(rd_byte[gi])
            );

            assign cnt_out[gi] = out_level;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------------

    // The byte is frozen at the start of the strobe so that a change of
    // the live count during the read cannot tear the bus value; side
    // effects on the latches happen only when the strobe ends.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_active_r <= 1'b0;
            rd_addr_r <= '0;
            data_out_r <= crl_pkg::IDLE_READ;
        end else if (rd_start) begin
            rd_active_r <= 1'b1;
            rd_addr_r <= addr;
            if (addr == crl_pkg::ADDR_CTRL_WORD) begin
                data_out_r <= crl_pkg::IDLE_READ;
            end else begin
                data_out_r <= rd_byte[addr];
            end
        end else if (rd_end) begin
            rd_active_r <= 1'b0;
            rd_addr_r <= crl_pkg::ADDR_CTRL_WORD;
        end
    end

    assign data_out = data_out_r;
    assign data_oe = rd_active_r;

endmodule

// ==== sim/counter_readout_latch_bench.sv ====
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module counter_readout_latch_bench;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cs_n, rd_n, wr_n;
    logic [1:0] addr;
    logic [7:0] data_in, data_out;
    logic data_oe;
    logic [2:0] cnt_clk = 3'h0;
    logic [2:0] cnt_gate = 3'h7;
    logic [2:0] cnt_out;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;

    // ------------------------------------------------------------------
    // Clock, design and host
    // ------------------------------------------------------------------
    always #20 ref_clk = ~ref_clk;

    crl_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .cnt_clk(cnt_clk), .cnt_gate(cnt_gate), .cnt_out(cnt_out));

    crl_host_model h (.ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .addr(addr), .data_in(data_in), .data_out(data_out));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Count clocks are slow next to the bus clock so each edge is sampled.
    task automatic pulse(input int ch);
        @(posedge ref_clk) cnt_clk[ch] <= 1'b1;
        repeat (3) @(posedge ref_clk);
        cnt_clk[ch] <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic rx(input logic [1:0] a, input logic [7:0] e);
        logic [7:0] v;
        h.rd(a, v);
        `CHK("read byte", e, v)
    endtask

    // A hang is cut short well beyond the length of the sequence.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 20000) begin
            bad_count++;
            stop_test();
        end
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        h.wr(2'h3, 8'h30);
        h.wr(2'h0, 8'h34);
        h.wr(2'h0, 8'h12);
        h.wr(2'h3, 8'he2);
        rx(2'h0, 8'h70);
        pulse(0);
        pulse(0);
        h.wr(2'h3, 8'h00);
        pulse(0);
        pulse(0);
        h.wr(2'h3, 8'h00);
        rx(2'h0, 8'h33);
        rx(2'h0, 8'h12);
        h.wr(2'h3, 8'h00);
        rx(2'h0, 8'h31);
        h.wr(2'h0, 8'h78);
        rx(2'h0, 8'h12);
        h.wr(2'h3, 8'he2);
        rx(2'h0, 8'h30);
        h.wr(2'h0, 8'h56);
        h.wr(2'h3, 8'he2);
        rx(2'h0, 8'h70);
        pulse(0);
        cnt_gate[0] <= 1'b0;
        pulse(0);
        rx(2'h0, 8'h78);
        rx(2'h0, 8'h56);
        cnt_gate[0] <= 1'b1;
        // Two counters latched by one command, read in the opposite order.
        h.wr(2'h3, 8'h74);
        h.wr(2'h1, 8'h02);
        h.wr(2'h1, 8'h01);
        h.wr(2'h3, 8'hb0);
        h.wr(2'h2, 8'h04);
        h.wr(2'h2, 8'h03);
        pulse(1);
        pulse(2);
        h.wr(2'h3, 8'h40);
        h.wr(2'h3, 8'hcc);
        pulse(1);
        pulse(2);
        h.wr(2'h3, 8'hc4);
        rx(2'h2, 8'h30);
        rx(2'h2, 8'h04);
        rx(2'h2, 8'h03);
        rx(2'h1, 8'h34);
        rx(2'h1, 8'h02);
        rx(2'h1, 8'h01);
        // Single byte count run down to zero drives the output high.
        h.wr(2'h3, 8'h10);
        h.wr(2'h0, 8'h02);
        repeat (3) pulse(0);
        `CHK("output pin", 1'b1, cnt_out[0])
        h.wr(2'h3, 8'he2);
        rx(2'h0, 8'h90);
        stop_test();
    end
endmodule

// ==== sim/crl_host_model.sv ====
`timescale 1ns/1ns
module crl_host_model (
    // Clock
    input wire logic ref_clk,
    // Parallel host port
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [1:0] addr,
    output logic [7:0] data_in,
    input wire logic [7:0] data_out
);
    // ------------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------------
    // Idle bus at time zero; strobes stay high until reset is over.
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 2'h0;
        data_in = 8'h00;
    end

    // Write strobe low for one cycle, then a high gap before the next strobe.
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        addr <= a;
        data_in <= d;
        @(posedge ref_clk);
        wr_n <= 1'b1;
        cs_n <= 1'b1;
        @(posedge ref_clk);
        data_in <= ~d;  // Released bus shows no stale value.
        @(posedge ref_clk);
    endtask

    // Read data is taken once the registered answer has landed.
    task automatic rd(input logic [1:0] a, output logic [7:0] q);
        @(posedge ref_clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        addr <= a;
        repeat (2) @(posedge ref_clk);
        #1 q = data_out;
        @(posedge ref_clk);
        rd_n <= 1'b1;
        cs_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
    endtask
endmodule

// ==== sim/crl_top_chk.sv ====
`timescale 1ns/1ns
module crl_top_chk #(
    parameter int NUM_CH = 3
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [1:0] addr,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic [NUM_CH-1:0] cnt_clk,
    input wire logic [NUM_CH-1:0] cnt_gate,
    input wire logic [NUM_CH-1:0] cnt_out
);
    // ------------------------------------------------------------------
    // Port protocol checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_oe_rise: assert property (!rd_n && !cs_n && $past(rd_n) |=> data_oe)
        else $error("read answer late");
    a_oe_hold: assert property (data_oe && !rd_n |=> data_oe)
        else $error("read answer dropped early");
    a_oe_drop: assert property (data_oe && rd_n |=> !data_oe)
        else $error("data enable held too long");
    a_oe_cause: assert property ($rose(data_oe) |-> $past(!rd_n && !cs_n))
        else $error("data enable without read");
    a_data_frozen: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
        else $error("read data changed mid strobe");
    a_ctrl_idle: assert property ($rose(data_oe) && $past(addr) == 2'h3 |->
        data_out == crl_pkg::IDLE_READ)
        else $error("control port read not idle");
    a_no_oe_write: assert property (!wr_n && !cs_n |-> !data_oe)
        else $error("bus driven during write");
    // The control word takes effect one cycle after the strobe ends.
    a_cw_out_low: assert property ($rose(wr_n) && !$past(cs_n) && $past(addr) == 2'h3 &&
        $past(data_in[7:4]) == 4'h1 |=> ##1 !cnt_out[0])
        else $error("output not low after control word");

    c_read: cover property ($rose(data_oe));
    c_write: cover property ($rose(wr_n));
    c_out_high: cover property ($rose(cnt_out[0]));
endmodule

bind crl_top crl_top_chk #(.NUM_CH(NUM_CH)) u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .cnt_clk(cnt_clk), .cnt_gate(cnt_gate), .cnt_out(cnt_out)
);
